// *** rtl/hbgs_bridge.v ***
`timescale 1ns/10ps
`include "hbgs_consts.vh"

module hbgs_bridge (
    // Clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // Command
    input wire cmd_strobe_in,
    input wire [1:0] bridge_drive_select_in,
    input wire charge_pump_enable_in,
    input wire bridge_pwm_enable_in,
    // Phase times in microseconds
    input wire [`HBGS_TIME_W-1:0] guard_time_in,
    input wire [`HBGS_TIME_W-1:0] blank_time_in,
    input wire [`HBGS_TIME_W-1:0] filter_time_in,
    // PWM path
    input wire pwm_high_in,
    input wire pwm_low_in,
    input wire pwm_high_valid_in,
    input wire freewheel_active_enable_in,
    input wire pwm_input_count_select_in,
    input wire active_fw_detect_enable_in,
    input wire phase_above_high_in,
    input wire phase_below_low_in,
    input wire [1:0] gate_control_scheme_in,
    input wire pre_phase_in,
    input wire pre_on_in,
    // Gate actions
    output reg [2:0] high_drive_out,
    output reg [2:0] low_drive_out,
    output reg high_is_active_out,
    output reg busy_out
);
    localparam ST_IDLE = 4'h1;
    localparam ST_GUARD = 4'h2;
    localparam ST_CHARGE = 4'h4;
    localparam ST_HOLD = 4'h8;

    localparam [`HBGS_CNT_W-1:0] CYC_PER_US =
        `HBGS_TIME_UNIT_NS / `HBGS_CLK_PERIOD_NS;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [`HBGS_CNT_W-1:0] count;
    reg [`HBGS_CNT_W-1:0] next_count;
    reg target_high;
    reg target_off;
    reg high_on;
    reg low_on;
    reg pwm_high_prev;
    reg pwm_low_prev;
    wire static_mode;
    wire charge_high;
    wire [`HBGS_CNT_W-1:0] guard_cyc;
    wire [`HBGS_CNT_W-1:0] charge_cyc;
    wire [`HBGS_CNT_W-1:0] blank_sum;
    reg det_high_active;

    assign static_mode = charge_pump_enable_in & ~bridge_pwm_enable_in;
    assign charge_high = cmd_strobe_in ? (bridge_drive_select_in == `HBGS_SEL_HIGH_ON) :
        target_high;
    assign blank_sum = {{(`HBGS_CNT_W-`HBGS_TIME_W){1'b0}}, blank_time_in}
        + {{(`HBGS_CNT_W-`HBGS_TIME_W){1'b0}}, filter_time_in};
    assign guard_cyc = {{(`HBGS_CNT_W-`HBGS_TIME_W){1'b0}}, guard_time_in} * CYC_PER_US;
    assign charge_cyc = blank_sum * CYC_PER_US;

    always @* begin
        if (!active_fw_detect_enable_in) begin
            det_high_active = pwm_high_valid_in;
        end else if (phase_above_high_in) begin
            det_high_active = 1'b0;
        end else if (phase_below_low_in) begin
            det_high_active = 1'b1;
        end else begin
            det_high_active = pwm_high_valid_in;
        end
    end

    always @* begin
        next_state = state;
        next_count = count;
        case (state)
            ST_IDLE, ST_HOLD: begin
            end
            ST_GUARD: begin
                if (count <= 16'h0001) begin
                    next_state = target_off ? ST_HOLD : ST_CHARGE;
                    next_count = charge_cyc;
                end else begin
                    next_count = count - 16'h0001;
                end
            end
            ST_CHARGE: begin
                if (count <= 16'h0001) begin
                    next_state = ST_HOLD;
                end else begin
                    next_count = count - 16'h0001;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (cmd_strobe_in && static_mode) begin
            case (bridge_drive_select_in)
                `HBGS_SEL_HIGH_ON, `HBGS_SEL_LOW_ON: begin
                    // Guard only when the opposite switch is on
                    if ((bridge_drive_select_in == `HBGS_SEL_HIGH_ON && low_on) ||
                        (bridge_drive_select_in == `HBGS_SEL_LOW_ON && high_on)) begin
                        next_state = ST_GUARD;
                        next_count = guard_cyc;
                    end else begin
                        next_state = ST_CHARGE;
                        next_count = charge_cyc;
                    end
                end
                default: begin
                    next_state = ST_GUARD;
                    next_count = guard_cyc;
                end
            endcase
        end
    end

    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            count <= 16'h0000;
            target_high <= 1'b0;
            target_off <= 1'b1;
            high_on <= 1'b0;
            low_on <= 1'b0;
            high_drive_out <= `HBGS_DRV_PASSIVE;
            low_drive_out <= `HBGS_DRV_PASSIVE;
            high_is_active_out <= 1'b0;
            busy_out <= 1'b0;
            pwm_high_prev <= 1'b0;
            pwm_low_prev <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            pwm_high_prev <= pwm_high_in;
            pwm_low_prev <= pwm_low_in;
            busy_out <= (next_state == ST_GUARD) || (next_state == ST_CHARGE);
            if (cmd_strobe_in && static_mode) begin
                target_high <= (bridge_drive_select_in == `HBGS_SEL_HIGH_ON);
                target_off <= (bridge_drive_select_in == `HBGS_SEL_PASSIVE) ||
                    (bridge_drive_select_in == `HBGS_SEL_BOTH_OFF);
            end
            if ((pwm_high_in & ~pwm_high_prev) | (pwm_low_in & ~pwm_low_prev)) begin
                high_is_active_out <= det_high_active;
            end
            if (!charge_pump_enable_in) begin
                high_drive_out <= `HBGS_DRV_PASSIVE;
                low_drive_out <= `HBGS_DRV_PASSIVE;
                high_on <= 1'b0;
                low_on <= 1'b0;
            end else if (bridge_pwm_enable_in) begin
                if (pre_phase_in && gate_control_scheme_in != `HBGS_AGC_NONE) begin
                    high_drive_out <= (pwm_high_in == pre_on_in) ?
                        (pre_on_in ? `HBGS_DRV_PRECHARGE : `HBGS_DRV_PREDISCHARGE) :
                        `HBGS_DRV_HOLD_OFF;
                    low_drive_out <= (pwm_low_in == pre_on_in) ?
                        (pre_on_in ? `HBGS_DRV_PRECHARGE : `HBGS_DRV_PREDISCHARGE) :
                        `HBGS_DRV_HOLD_OFF;
                end else begin
                    high_drive_out <= pwm_high_in ? `HBGS_DRV_CHARGE : `HBGS_DRV_DISCHARGE;
                    low_drive_out <= pwm_low_in ? `HBGS_DRV_CHARGE : `HBGS_DRV_DISCHARGE;
                end
                high_on <= pwm_high_in;
                low_on <= pwm_low_in;
            end else begin
                case (next_state)
                    ST_GUARD: begin
                        high_drive_out <= `HBGS_DRV_DISCHARGE;
                        low_drive_out <= `HBGS_DRV_DISCHARGE;
                        high_on <= 1'b0;
                        low_on <= 1'b0;
                    end
                    ST_CHARGE: begin
                        high_drive_out <= charge_high ?
                            `HBGS_DRV_CHARGE : `HBGS_DRV_HARD_OFF;
                        low_drive_out <= charge_high ?
                            `HBGS_DRV_HARD_OFF : `HBGS_DRV_CHARGE;
                    end
                    ST_HOLD: begin
                        if (target_off) begin
                            high_drive_out <= `HBGS_DRV_HOLD_OFF;
                            low_drive_out <= `HBGS_DRV_HOLD_OFF;
                            high_on <= 1'b0;
                            low_on <= 1'b0;
                        end else begin
                            high_drive_out <= target_high ?
                                `HBGS_DRV_HOLD_ON : `HBGS_DRV_HOLD_OFF;
                            low_drive_out <= target_high ?
                                `HBGS_DRV_HOLD_OFF : `HBGS_DRV_HOLD_ON;
                            high_on <= target_high;
                            low_on <= ~target_high;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule

// *** pkg/hbgs_consts.vh ***
`ifndef HBGS_CONSTS_VH
`define HBGS_CONSTS_VH

// Drive select codes
`define HBGS_SEL_PASSIVE 2'h0
`define HBGS_SEL_LOW_ON 2'h1
`define HBGS_SEL_HIGH_ON 2'h2
`define HBGS_SEL_BOTH_OFF 2'h3

// Gate-control scheme codes
`define HBGS_AGC_NONE 2'h0
`define HBGS_AGC_FIXED 2'h1

// Gate drive action codes per gate
`define HBGS_DRV_PASSIVE 3'h0
`define HBGS_DRV_CHARGE 3'h1
`define HBGS_DRV_DISCHARGE 3'h2
`define HBGS_DRV_HARD_OFF 3'h3
`define HBGS_DRV_HOLD_ON 3'h4
`define HBGS_DRV_HOLD_OFF 3'h5
`define HBGS_DRV_PRECHARGE 3'h6
`define HBGS_DRV_PREDISCHARGE 3'h7

// Hold current steps
`define HBGS_HOLD_STEP_LOW 6'h0f
`define HBGS_HOLD_STEP_HIGH 6'h14

// Chip-select execution latency
`define HBGS_CS_LATENCY_NS 3000
`define HBGS_CS_SYNC_CYCLES 3

// Clock period and time unit
`define HBGS_CLK_PERIOD_NS 16'h0028
`define HBGS_TIME_UNIT_NS 16'h03e8

// Timer width (time fields counted in microseconds)
`define HBGS_TIME_W 8
`define HBGS_CNT_W 16

`endif

// *** rtl/hbgs_sequencer.v ***
`timescale 1ns/10ps
`include "hbgs_consts.vh"

// How it works
// - Opposite on: guard phase, discharge both gates
// - Then charge gate, hard-off opposite, blank+filter
// - After filter, hold on and hold off
// - Chip select synchronised, latency within 3 us
// - Both actively off: skip guard, charge directly
// - Low-side activation mirrors high-side sequence
// - Both off: discharge for guard, then hold
// - PWM from three or six inputs
// - Phase node high: low side active
// - Phase node low: high side active
// - Between thresholds: next switch treated active
// - Detection off: PWM switch is active
// - Adaptive schemes apply pre-charge and pre-discharge
// - Scheme zero omits pre phases
// - Fixed scheme uses initial pre currents (code gives only the pre-charge one)
// - Freewheel needs enable, PWM enable, count zero
// - Guard time in PWM only with freewheel
// - Freewheel: active off turns opposite on
// - Charge pump and drive select set states
// - Hold select picks step fifteen or twenty
// - Static sequences need PWM off, pump on

module hbgs_sequencer (
    // Clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // Host chip select pin
    input wire spi_cs_n_in,
    // Configuration
    input wire charge_pump_enable_in,
    input wire hold_current_select_in,
    input wire [3:0] static_gate_current_code_in,
    input wire [5:0] bridge_drive_select_in,
    input wire [2:0] bridge_pwm_enable_in,
    input wire [2:0] freewheel_active_enable_in,
    input wire pwm_input_count_select_in,
    input wire active_fw_detect_enable_in,
    input wire [1:0] gate_control_scheme_in,
    input wire [3:0] initial_precharge_current_in,
    input wire [3:0] initial_predischarge_current_in,
    input wire [`HBGS_TIME_W-1:0] cross_conduction_guard_time_in,
    input wire [`HBGS_TIME_W-1:0] overvoltage_blank_time_in,
    input wire [`HBGS_TIME_W-1:0] drain_source_filter_time_in,
    input wire [`HBGS_TIME_W-1:0] precharge_time_in,
    // PWM pins, high then low per bridge
    input wire [5:0] pwm_pin_in,
    // Phase node comparators
    input wire [2:0] phase_above_high_in,
    input wire [2:0] phase_below_low_in,
    // Gate drive actions, three bits per gate
    output reg [8:0] high_drive_out,
    output reg [8:0] low_drive_out,
    output reg [5:0] hold_step_out,
    output reg [3:0] drive_current_code_out,
    output reg [3:0] pre_current_code_out,
    output reg [2:0] high_active_out,
    output reg [2:0] busy_out
);
    localparam [`HBGS_CNT_W-1:0] CYC_PER_US =
        `HBGS_TIME_UNIT_NS / `HBGS_CLK_PERIOD_NS;

    reg cs_meta;
    reg cs_sync;
    reg cs_prev;
    reg [5:0] pwm_meta;
    reg [5:0] pwm_sync;
    reg [2:0] cmp_hi_meta;
    reg [2:0] cmp_hi_sync;
    reg [2:0] cmp_lo_meta;
    reg [2:0] cmp_lo_sync;
    reg [5:0] pwm_prev;
    wire cs_rise;
    wire [8:0] hdrv;
    wire [8:0] ldrv;
    wire [2:0] hact;
    wire [2:0] bsy;

    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            pwm_meta <= 6'h00;
            pwm_sync <= 6'h00;
            pwm_prev <= 6'h00;
            cmp_hi_meta <= 3'h0;
            cmp_hi_sync <= 3'h0;
            cmp_lo_meta <= 3'h0;
            cmp_lo_sync <= 3'h0;
        end else begin
            cs_meta <= spi_cs_n_in;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            pwm_meta <= pwm_pin_in;
            pwm_sync <= pwm_meta;
            pwm_prev <= pwm_sync;
            cmp_hi_meta <= phase_above_high_in;
            cmp_hi_sync <= cmp_hi_meta;
            cmp_lo_meta <= phase_below_low_in;
            cmp_lo_sync <= cmp_lo_meta;
        end
    end

    assign cs_rise = cs_sync & ~cs_prev;

    genvar b;
    generate
        for (b = 0; b < 3; b = b + 1) begin : g_bridge
            wire afw;
            wire hi_cmd;
            wire lo_cmd;
            reg hi_pwm;
            reg lo_pwm;
            reg pre_on;
            reg [`HBGS_CNT_W-1:0] pre_cnt;
            reg [`HBGS_CNT_W-1:0] gap_cnt;
            wire pre_phase;
            wire pwm_edge;

            assign afw = freewheel_active_enable_in[b] & bridge_pwm_enable_in[b]
                & ~pwm_input_count_select_in;
            // Low pin feeds lo_cmd only with six inputs
            assign hi_cmd = pwm_sync[2*b+1];
            assign lo_cmd = pwm_input_count_select_in & pwm_sync[2*b];
            assign pwm_edge = (pwm_sync[2*b+1] ^ pwm_prev[2*b+1]) |
                (pwm_sync[2*b] ^ pwm_prev[2*b]);
            assign pre_phase = (pre_cnt != 16'h0000);

            always @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    hi_pwm <= 1'b0;
                    lo_pwm <= 1'b0;
                    pre_on <= 1'b0;
                    pre_cnt <= 16'h0000;
                    gap_cnt <= 16'h0000;
                end else begin
                    if (pwm_edge) begin
                        pre_on <= pwm_sync[2*b+1] | pwm_sync[2*b];
                        pre_cnt <= {{(`HBGS_CNT_W-`HBGS_TIME_W){1'b0}},
                            precharge_time_in} * CYC_PER_US;
                        gap_cnt <= freewheel_active_enable_in[b] ?
                            {{(`HBGS_CNT_W-`HBGS_TIME_W){1'b0}},
                            cross_conduction_guard_time_in} * CYC_PER_US :
                            16'h0000;
                    end else begin
                        if (pre_cnt != 16'h0000) begin
                            pre_cnt <= pre_cnt - 16'h0001;
                        end
                        if (gap_cnt != 16'h0000) begin
                            gap_cnt <= gap_cnt - 16'h0001;
                        end
                    end
                    if (gap_cnt != 16'h0000 || pwm_edge) begin
                        hi_pwm <= 1'b0;
                        lo_pwm <= 1'b0;
                    end else if (afw) begin
                        hi_pwm <= hi_cmd;
                        lo_pwm <= ~hi_cmd;
                    end else begin
                        hi_pwm <= hi_cmd;
                        lo_pwm <= lo_cmd & ~hi_cmd;
                    end
                end
            end

            hbgs_bridge u_bridge (
                .core_clk_in(core_clk_in),
                .sys_rst_in(sys_rst_in),
                .cmd_strobe_in(cs_rise),
                .bridge_drive_select_in(bridge_drive_select_in[2*b+1:2*b]),
                .charge_pump_enable_in(charge_pump_enable_in),
                .bridge_pwm_enable_in(bridge_pwm_enable_in[b]),
                .guard_time_in(cross_conduction_guard_time_in),
                .blank_time_in(overvoltage_blank_time_in),
                .filter_time_in(drain_source_filter_time_in),
                .pwm_high_in(hi_pwm),
                .pwm_low_in(lo_pwm),
                .pwm_high_valid_in(hi_cmd),
                .freewheel_active_enable_in(freewheel_active_enable_in[b]),
                .pwm_input_count_select_in(pwm_input_count_select_in),
                .active_fw_detect_enable_in(active_fw_detect_enable_in),
                .phase_above_high_in(cmp_hi_sync[b]),
                .phase_below_low_in(cmp_lo_sync[b]),
                .gate_control_scheme_in(gate_control_scheme_in),
                .pre_phase_in(pre_phase),
                .pre_on_in(pre_on),
                .high_drive_out(hdrv[3*b+2:3*b]),
                .low_drive_out(ldrv[3*b+2:3*b]),
                .high_is_active_out(hact[b]),
                .busy_out(bsy[b])
            );
        end
    endgenerate

    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            high_drive_out <= 9'h000;
            low_drive_out <= 9'h000;
            hold_step_out <= `HBGS_HOLD_STEP_LOW;
            drive_current_code_out <= 4'h0;
            pre_current_code_out <= 4'h0;
            high_active_out <= 3'h0;
            busy_out <= 3'h0;
        end else begin
            high_drive_out <= hdrv;
            low_drive_out <= ldrv;
            hold_step_out <= hold_current_select_in ?
                `HBGS_HOLD_STEP_HIGH : `HBGS_HOLD_STEP_LOW;
            drive_current_code_out <= static_gate_current_code_in;
            pre_current_code_out <= (gate_control_scheme_in == `HBGS_AGC_FIXED) ?
                initial_precharge_current_in : initial_predischarge_current_in;
            high_active_out <= hact;
            busy_out <= bsy;
        end
    end
endmodule

// *** testbench/hbgs_sequencer_monitor.sv ***
`timescale 1ns/10ps
`include "hbgs_consts.vh"
module hbgs_sequencer_monitor (
    // Clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // Watched inputs
    input wire spi_cs_n_in,
    input wire charge_pump_enable_in,
    input wire hold_current_select_in,
    input wire [3:0] static_gate_current_code_in,
    input wire [2:0] bridge_pwm_enable_in,
    input wire [1:0] gate_control_scheme_in,
    input wire [3:0] initial_precharge_current_in,
    input wire [3:0] initial_predischarge_current_in,
    input wire [`HBGS_TIME_W-1:0] cross_conduction_guard_time_in,
    input wire [`HBGS_TIME_W-1:0] overvoltage_blank_time_in,
    input wire [`HBGS_TIME_W-1:0] drain_source_filter_time_in,
    // Watched outputs
    input wire [8:0] high_drive_out,
    input wire [8:0] low_drive_out,
    input wire [5:0] hold_step_out,
    input wire [3:0] drive_current_code_out,
    input wire [3:0] pre_current_code_out,
    input wire [2:0] busy_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    wire [2:0] h0 = high_drive_out[2:0];
    wire [2:0] l0 = low_drive_out[2:0];
    wire grd = h0 == `HBGS_DRV_DISCHARGE && l0 == `HBGS_DRV_DISCHARGE;
    wire chg = (h0 == `HBGS_DRV_CHARGE && l0 == `HBGS_DRV_HARD_OFF) ||
        (l0 == `HBGS_DRV_CHARGE && h0 == `HBGS_DRV_HARD_OFF);
    wire stat = charge_pump_enable_in && !bridge_pwm_enable_in[0];
    reg [15:0] grd_cnt;
    reg [15:0] chg_cnt;
    always @(posedge core_clk_in) begin
        grd_cnt <= (grd && !sys_rst_in) ? grd_cnt + 16'h0001 : 16'h0000;
        chg_cnt <= (chg && !sys_rst_in) ? chg_cnt + 16'h0001 : 16'h0000;
    end
    a_guard_length: assert property (
        $fell(grd) && stat |-> grd_cnt == 16'h0019 * cross_conduction_guard_time_in)
        else $error("guard phase length wrong");
    a_charge_length: assert property (
        $fell(chg) && stat |-> chg_cnt == 16'h0019 *
        (overvoltage_blank_time_in + drain_source_filter_time_in))
        else $error("charge phase length wrong");
    a_guard_exit: assert property (
        $fell(grd) && stat |-> chg || (h0 == `HBGS_DRV_HOLD_OFF && l0 == `HBGS_DRV_HOLD_OFF))
        else $error("wrong phase after guard");
    a_charge_to_hold: assert property (
        $fell(chg) && stat |-> ($past(h0) == `HBGS_DRV_CHARGE) ?
        (h0 == `HBGS_DRV_HOLD_ON && l0 == `HBGS_DRV_HOLD_OFF) :
        (l0 == `HBGS_DRV_HOLD_ON && h0 == `HBGS_DRV_HOLD_OFF))
        else $error("wrong hold after charge");
    a_cs_latency: assert property (
        $rose(spi_cs_n_in) && stat |-> ##[1:75] busy_out[0])
        else $error("command not started in time");
    a_pump_passive: assert property (
        !charge_pump_enable_in [*3] |-> high_drive_out == 9'h000 && low_drive_out == 9'h000)
        else $error("drives not passive with pump off");
    a_hold_step_map: assert property (
        $stable(hold_current_select_in) [*2] |->
        hold_step_out == (hold_current_select_in ? 6'h14 : 6'h0f))
        else $error("hold step wrong");
    a_static_code: assert property (
        $stable(static_gate_current_code_in) [*2] ##0 !$past(sys_rst_in) |->
        drive_current_code_out == static_gate_current_code_in)
        else $error("static current code wrong");
    a_pre_code_sel: assert property (
        $stable({gate_control_scheme_in, initial_precharge_current_in,
        initial_predischarge_current_in}) [*2] ##0 !$past(sys_rst_in) |->
        pre_current_code_out == (gate_control_scheme_in == 2'h1 ? initial_precharge_current_in
        : initial_predischarge_current_in))
        else $error("pre current code wrong");
    a_busy_phase: assert property (
        stat |-> busy_out[0] == (grd || chg))
        else $error("busy flag does not match phase");
    c_guard: cover property ($fell(grd) && stat);
    c_charge: cover property ($fell(chg) && stat);
    c_hold_high: cover property (hold_step_out == 6'h14);
endmodule

bind hbgs_sequencer hbgs_sequencer_monitor i_mon (.*);

// *** testbench/hbgs_bridge_model.sv ***
`timescale 1ns/10ps
`include "hbgs_consts.vh"
module hbgs_bridge_model (
    // Gate actions from the sequencer
    input wire [8:0] high_drive_in,
    input wire [8:0] low_drive_in,
    // Load current direction, high lifts the node while both gates are off
    input wire [2:0] load_dir_in,
    // Phase node comparators
    output reg [2:0] phase_above_high_out,
    output reg [2:0] phase_below_low_out
);
    integer b;
    reg hon;
    reg lon;
    function is_on(input [2:0] c);
        is_on = c == `HBGS_DRV_CHARGE || c == `HBGS_DRV_HOLD_ON || c == `HBGS_DRV_PRECHARGE;
    endfunction
    always @* begin
        for (b = 0; b < 3; b = b + 1) begin
            hon = is_on(high_drive_in[3*b +: 3]);
            lon = is_on(low_drive_in[3*b +: 3]);
            phase_above_high_out[b] = hon || (!lon && load_dir_in[b]);
            phase_below_low_out[b] = lon || (!hon && !load_dir_in[b]);
        end
    end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
`include "hbgs_consts.vh"
module tb_top;
    localparam integer g_len = 25;
    localparam integer c_len = 50;
    localparam [8:0] d_dis = {3{`HBGS_DRV_DISCHARGE}};
    localparam [8:0] d_chg = {3{`HBGS_DRV_CHARGE}};
    localparam [8:0] d_hard = {3{`HBGS_DRV_HARD_OFF}};
    localparam [8:0] d_on = {3{`HBGS_DRV_HOLD_ON}};
    localparam [8:0] d_off = {3{`HBGS_DRV_HOLD_OFF}};
    reg core_clk_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg spi_cs_n_in = 1'b1;
    reg charge_pump_enable_in = 1'b1;
    reg hold_current_select_in = 1'b0;
    reg [3:0] static_gate_current_code_in = 4'ha;
    reg [5:0] bridge_drive_select_in = 6'h00;
    reg [2:0] bridge_pwm_enable_in = 3'h0;
    reg [2:0] freewheel_active_enable_in = 3'h0;
    reg pwm_input_count_select_in = 1'b0;
    reg active_fw_detect_enable_in = 1'b0;
    reg [1:0] gate_control_scheme_in = 2'h0;
    reg [3:0] initial_precharge_current_in = 4'h5;
    reg [3:0] initial_predischarge_current_in = 4'hc;
    reg [`HBGS_TIME_W-1:0] guard_t = 8'h01;
    reg [`HBGS_TIME_W-1:0] blank_t = 8'h01;
    reg [`HBGS_TIME_W-1:0] filter_t = 8'h01;
    reg [`HBGS_TIME_W-1:0] pre_t = 8'h00;
    reg [5:0] pwm_pin_in = 6'h00;
    reg [2:0] load_dir = 3'h0;
    wire [2:0] above;
    wire [2:0] below;
    wire [8:0] high_drive_out;
    wire [8:0] low_drive_out;
    wire [5:0] hold_step_out;
    wire [3:0] drive_current_code_out;
    wire [3:0] pre_current_code_out;
    wire [2:0] high_active_out;
    wire [2:0] busy_out;
    integer n_fail = 0;
    integer comparisons = 0;
    integer s;
    always #20 core_clk_in = ~core_clk_in;
    hbgs_sequencer i_dut (.core_clk_in, .sys_rst_in, .spi_cs_n_in, .charge_pump_enable_in,
        .hold_current_select_in, .static_gate_current_code_in, .bridge_drive_select_in,
        .bridge_pwm_enable_in, .freewheel_active_enable_in, .pwm_input_count_select_in,
        .active_fw_detect_enable_in, .gate_control_scheme_in, .initial_precharge_current_in,
        .initial_predischarge_current_in, .cross_conduction_guard_time_in(guard_t),
        .overvoltage_blank_time_in(blank_t), .drain_source_filter_time_in(filter_t),
        .precharge_time_in(pre_t), .pwm_pin_in, .phase_above_high_in(above),
        .phase_below_low_in(below), .high_drive_out, .low_drive_out, .hold_step_out,
        .drive_current_code_out, .pre_current_code_out, .high_active_out, .busy_out);
    hbgs_bridge_model i_model (.high_drive_in(high_drive_out), .low_drive_in(low_drive_out),
        .load_dir_in(load_dir), .phase_above_high_out(above), .phase_below_low_out(below));
    task stop_test;
        begin
            $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task check(input logic [17:0] got, input logic [17:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wait_change(output integer n);
        reg [17:0] prev;
        begin
            prev = {high_drive_out, low_drive_out};
            n = 0;
            while ({high_drive_out, low_drive_out} === prev && n < 2000) begin
                @(posedge core_clk_in);
                #1;
                n = n + 1;
            end
        end
    endtask
    task cmd(input [5:0] sel);
        integer n;
        begin
            @(posedge core_clk_in);
            bridge_drive_select_in <= sel;
            spi_cs_n_in <= 1'b0;
            repeat (2) @(posedge core_clk_in);
            spi_cs_n_in <= 1'b1;
            #1;
            wait_change(n);
            check(n <= 75, 18'h1);
        end
    endtask
    task phase(input [8:0] h, input [8:0] l, input integer len);
        integer n;
        begin
            check({high_drive_out, low_drive_out}, {h, l});
            if (len > 0) begin
                wait_change(n);
                check(n, len);
            end
        end
    endtask
    task settle(input integer n);
        begin
            repeat (n) @(posedge core_clk_in);
            #1;
        end
    endtask
    initial begin
        #(40 * 20000);
        n_fail = n_fail + 1;
        stop_test;
    end
    initial begin
        repeat (20) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        settle(2);
        check({high_drive_out, low_drive_out}, 18'h0);
        check(hold_step_out, 6'h0f);
        cmd(6'h3f);
        phase(d_dis, d_dis, g_len);
        phase(d_off, d_off, 0);
        cmd(6'h2a);
        phase(d_chg, d_hard, c_len);
        phase(d_on, d_off, 0);
        cmd(6'h15);
        phase(d_dis, d_dis, g_len);
        phase(d_hard, d_chg, c_len);
        phase(d_off, d_on, 0);
        cmd(6'h2a);
        phase(d_dis, d_dis, g_len);
        phase(d_chg, d_hard, c_len);
        phase(d_on, d_off, 0);
        cmd(6'h00);
        phase(d_dis, d_dis, g_len);
        phase(d_off, d_off, 0);
        hold_current_select_in <= 1'b1;
        static_gate_current_code_in <= 4'h3;
        settle(3);
        check(hold_step_out, 6'h14);
        check(drive_current_code_out, 4'h3);
        for (s = 0; s < 4; s = s + 1) begin
            gate_control_scheme_in <= s[1:0];
            settle(3);
            check(pre_current_code_out, s == 1 ? 4'h5 : 4'hc);
        end
        cmd(6'h3f);
        settle(g_len + 5);
        bridge_pwm_enable_in <= 3'h1;
        settle(100);
        cmd(6'h2a);
        check(busy_out, 3'h6);
        for (s = 0; s < 3; s = s + 1) begin
            active_fw_detect_enable_in <= s != 2;
            load_dir <= (s == 1) ? 3'h0 : 3'h7;
            pwm_pin_in <= 6'h00;
            settle(20);
            pwm_pin_in <= 6'h02;
            settle(20);
            check(high_active_out[0], s != 0);
        end
        charge_pump_enable_in <= 1'b0;
        settle(4);
        check({high_drive_out, low_drive_out}, 18'h0);
        stop_test;
    end
endmodule
